/* File: rtl/bfu_params.svh */
// constants for the bit and flag instruction unit
`ifndef BFU_PARAMS_SVH
`define BFU_PARAMS_SVH

// status flag positions
`define BFU_FLAG_C      3'h0
`define BFU_FLAG_Z      3'h1
`define BFU_FLAG_N      3'h2
`define BFU_FLAG_V      3'h3
`define BFU_FLAG_S      3'h4
`define BFU_FLAG_H      3'h5
`define BFU_FLAG_T      3'h6
`define BFU_FLAG_I      3'h7

// widths, reset values and the plus one for branch targets
`define BFU_PC_W        16
`define BFU_IO_AW       5
`define BFU_STATUS_RST  8'h00
`define BFU_PC_ONE      16'h0001

`endif

/* File: rtl/bfu_pkg.sv */
// types for the bit and flag instruction unit
package bfu_pkg;

  typedef enum logic [4:0] {
    OP_BRANCH_IRQ_ON          = 5'h00,
    OP_BRANCH_IRQ_OFF         = 5'h01,
    OP_IO_BIT_RAISE           = 5'h02,
    OP_IO_BIT_DROP            = 5'h03,
    OP_LOGICAL_SHIFT_LEFT     = 5'h04,
    OP_LOGICAL_SHIFT_RIGHT    = 5'h05,
    OP_ROTATE_LEFT_VIA_CARRY  = 5'h06,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h07,
    OP_ARITH_SHIFT_RIGHT      = 5'h08,
    OP_NIBBLE_SWAP            = 5'h09,
    OP_INDEXED_FLAG_RAISE     = 5'h0A,
    OP_INDEXED_FLAG_DROP      = 5'h0B,
    OP_STORE_BIT_TO_T         = 5'h0C,
    OP_LOAD_BIT_FROM_T        = 5'h0D,
    OP_CARRY_RAISE            = 5'h0E,
    OP_CARRY_DROP             = 5'h0F,
    OP_NEGATIVE_RAISE         = 5'h10,
    OP_NEGATIVE_DROP          = 5'h11,
    OP_ZERO_RAISE             = 5'h12,
    OP_ZERO_DROP              = 5'h13,
    OP_GLOBAL_IRQ_ON          = 5'h14,
    OP_GLOBAL_IRQ_OFF         = 5'h15,
    OP_SIGNED_FLAG_RAISE      = 5'h16,
    OP_SIGNED_FLAG_DROP       = 5'h17,
    OP_OVERFLOW_RAISE         = 5'h18,
    OP_OVERFLOW_DROP          = 5'h19,
    OP_T_FLAG_RAISE           = 5'h1A,
    OP_T_FLAG_DROP            = 5'h1B,
    OP_HALF_CARRY_RAISE       = 5'h1C,
    OP_HALF_CARRY_DROP        = 5'h1D
  } bfu_op_e;

  typedef enum logic [2:0] {
    BFU_ST_IDLE = 3'h1,
    BFU_ST_IO   = 3'h2,
    BFU_ST_BR   = 3'h4
  } bfu_state_e;

endpackage : bfu_pkg

/* File: rtl/bfu_core.sv */
// bit and flag instruction unit: branches on I, io bit ops, shifts, flags
`timescale 1ns/1ns
`include "bfu_params.svh"

module bfu_core (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // instruction request
  input  wire logic                    op_valid,
  input  wire bfu_pkg::bfu_op_e        op_code,
  input  wire logic [7:0]              op_reg_val,
  input  wire logic [2:0]              op_bit,
  input  wire logic [`BFU_IO_AW-1:0]   op_io_addr,
  input  wire logic [6:0]              op_offset,
  input  wire logic [`BFU_PC_W-1:0]    pc_now,
  output logic                         op_ready_q,
  output logic                         done_q,
  // register file write back
  output logic                         reg_we_q,
  output logic [7:0]                   reg_wdata_q,
  // io register space
  output logic                         io_rd_q,
  output logic                         io_we_q,
  output logic [`BFU_IO_AW-1:0]        io_addr_q,
  output logic [7:0]                   io_wdata_q,
  input  wire logic [7:0]              io_rdata,
  // program counter
  output logic                         pc_load_q,
  output logic [`BFU_PC_W-1:0]         pc_next_q,
  // status flags
  output logic [7:0]                   status_q
);

  // ----------------------------------------------------------------
  // decode and datapath
  // ----------------------------------------------------------------
  bfu_pkg::bfu_state_e    state_q;
  logic                   accept;
  logic                   is_shift;
  logic                   is_reg_wr;
  logic                   is_io;
  logic                   br_taken;
  logic [7:0]             alu_res;
  logic                   c_new;
  logic                   fl_hit;
  logic [2:0]             fl_idx;
  logic                   fl_val;
  logic [7:0]             status_d;
  logic [`BFU_PC_W-1:0]   br_target;
  logic [`BFU_PC_W-1:0]   br_target_q;
  logic [2:0]             io_bit_q;
  logic                   io_val_q;

  assign accept = op_valid && op_ready_q;
  assign is_io  = (op_code == bfu_pkg::OP_IO_BIT_RAISE) ||
                  (op_code == bfu_pkg::OP_IO_BIT_DROP);
  // offset sign-extended; plus one skips past the branch itself
  assign br_target = pc_now + {{(`BFU_PC_W-7){op_offset[6]}}, op_offset}
                   + `BFU_PC_ONE;

  always_comb begin
    br_taken = 1'b0;
    case (op_code)
      bfu_pkg::OP_BRANCH_IRQ_ON:
        br_taken = status_q[`BFU_FLAG_I];
      bfu_pkg::OP_BRANCH_IRQ_OFF:
        br_taken = !status_q[`BFU_FLAG_I];
      default:                    br_taken = 1'b0;
    endcase
  end

  always_comb begin
    alu_res   = op_reg_val;
    c_new     = status_q[`BFU_FLAG_C];
    is_shift  = 1'b1;
    is_reg_wr = 1'b1;
    case (op_code)
      bfu_pkg::OP_LOGICAL_SHIFT_LEFT:
        {c_new, alu_res} = {op_reg_val, 1'b0};
      bfu_pkg::OP_LOGICAL_SHIFT_RIGHT:
        {alu_res, c_new} = {1'b0, op_reg_val};
      bfu_pkg::OP_ROTATE_LEFT_VIA_CARRY:
        {c_new, alu_res} = {op_reg_val, status_q[`BFU_FLAG_C]};
      bfu_pkg::OP_ROTATE_RIGHT_VIA_CARRY:
        {alu_res, c_new} = {status_q[`BFU_FLAG_C], op_reg_val};
      bfu_pkg::OP_ARITH_SHIFT_RIGHT:
        {alu_res, c_new} = {op_reg_val[7], op_reg_val};
      bfu_pkg::OP_NIBBLE_SWAP: begin
        alu_res  = {op_reg_val[3:0], op_reg_val[7:4]};
        is_shift = 1'b0;
      end
      bfu_pkg::OP_LOAD_BIT_FROM_T: begin
        alu_res[op_bit] = status_q[`BFU_FLAG_T];
        is_shift = 1'b0;
      end
      default: begin
        is_shift  = 1'b0;
        is_reg_wr = 1'b0;
      end
    endcase
  end

  // single flag instructions map onto one index and one value
  always_comb begin
    fl_hit = 1'b1;
    fl_idx = op_bit;
    fl_val = 1'b1;
    case (op_code)
      bfu_pkg::OP_INDEXED_FLAG_RAISE: fl_val = 1'b1;
      bfu_pkg::OP_INDEXED_FLAG_DROP:  fl_val = 1'b0;
      bfu_pkg::OP_STORE_BIT_TO_T: begin
        fl_idx = `BFU_FLAG_T;
        fl_val = op_reg_val[op_bit];
      end
      bfu_pkg::OP_CARRY_RAISE:       {fl_idx, fl_val} = {`BFU_FLAG_C, 1'b1};
      bfu_pkg::OP_CARRY_DROP:        {fl_idx, fl_val} = {`BFU_FLAG_C, 1'b0};
      bfu_pkg::OP_NEGATIVE_RAISE:    {fl_idx, fl_val} = {`BFU_FLAG_N, 1'b1};
      bfu_pkg::OP_NEGATIVE_DROP:     {fl_idx, fl_val} = {`BFU_FLAG_N, 1'b0};
      bfu_pkg::OP_ZERO_RAISE:        {fl_idx, fl_val} = {`BFU_FLAG_Z, 1'b1};
      bfu_pkg::OP_ZERO_DROP:         {fl_idx, fl_val} = {`BFU_FLAG_Z, 1'b0};
      bfu_pkg::OP_GLOBAL_IRQ_ON:     {fl_idx, fl_val} = {`BFU_FLAG_I, 1'b1};
      bfu_pkg::OP_GLOBAL_IRQ_OFF:    {fl_idx, fl_val} = {`BFU_FLAG_I, 1'b0};
      bfu_pkg::OP_SIGNED_FLAG_RAISE: {fl_idx, fl_val} = {`BFU_FLAG_S, 1'b1};
      bfu_pkg::OP_SIGNED_FLAG_DROP:  {fl_idx, fl_val} = {`BFU_FLAG_S, 1'b0};
      bfu_pkg::OP_OVERFLOW_RAISE:
        {fl_idx, fl_val} = {`BFU_FLAG_V, 1'b1};
      bfu_pkg::OP_OVERFLOW_DROP:
        {fl_idx, fl_val} = {`BFU_FLAG_V, 1'b0};
      bfu_pkg::OP_T_FLAG_RAISE:      {fl_idx, fl_val} = {`BFU_FLAG_T, 1'b1};
      bfu_pkg::OP_T_FLAG_DROP:       {fl_idx, fl_val} = {`BFU_FLAG_T, 1'b0};
      bfu_pkg::OP_HALF_CARRY_RAISE:
        {fl_idx, fl_val} = {`BFU_FLAG_H, 1'b1};
      bfu_pkg::OP_HALF_CARRY_DROP:   {fl_idx, fl_val} = {`BFU_FLAG_H, 1'b0};
      default:                       fl_hit = 1'b0;
    endcase
  end

  always_comb begin
    status_d = status_q;
    if (is_shift) begin
      // V is N xor C of the fresh result; S is left alone here
      status_d[`BFU_FLAG_C] = c_new;
      status_d[`BFU_FLAG_Z] = (alu_res == 8'h00);
      status_d[`BFU_FLAG_N] = alu_res[7];
      status_d[`BFU_FLAG_V] = alu_res[7] ^ c_new;
    end else if (fl_hit) begin
      status_d[fl_idx] = fl_val;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q    <= bfu_pkg::BFU_ST_IDLE;
      op_ready_q <= 1'b1;
    end else begin
      case (state_q)
        bfu_pkg::BFU_ST_IDLE: begin
          if (accept && is_io) begin
            state_q    <= bfu_pkg::BFU_ST_IO;
            op_ready_q <= 1'b0;
          end else if (accept && br_taken) begin
            state_q    <= bfu_pkg::BFU_ST_BR;
            op_ready_q <= 1'b0;
          end
        end
        bfu_pkg::BFU_ST_IO, bfu_pkg::BFU_ST_BR: begin
          state_q    <= bfu_pkg::BFU_ST_IDLE;
          op_ready_q <= 1'b1;
        end
        default: begin
          state_q    <= bfu_pkg::BFU_ST_IDLE;
          op_ready_q <= 1'b1;
        end
      endcase
    end
  end

  // one-cycle ops finish at the first edge, io and taken branch at the second
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else if (state_q != bfu_pkg::BFU_ST_IDLE) begin
      done_q <= 1'b1;
    end else begin
      done_q <= accept && !is_io && !br_taken;
    end
  end

  // ----------------------------------------------------------------
  // status, register write back, pc
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_q <= `BFU_STATUS_RST;
    end else if (accept) begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_we_q    <= 1'b0;
      reg_wdata_q <= 8'h00;
    end else begin
      reg_we_q <= accept && is_reg_wr;
      if (accept && is_reg_wr) begin
        reg_wdata_q <= alu_res;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      br_target_q <= '0;
      pc_load_q   <= 1'b0;
      pc_next_q   <= '0;
    end else begin
      pc_load_q <= (state_q == bfu_pkg::BFU_ST_BR);
      if (accept && br_taken) begin
        br_target_q <= br_target;
      end
      if (state_q == bfu_pkg::BFU_ST_BR) begin
        pc_next_q <= br_target_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // io read-modify-write
  // ----------------------------------------------------------------
  // io_rdata must be valid in the cycle io_rd_q is high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      io_rd_q    <= 1'b0;
      io_we_q    <= 1'b0;
      io_addr_q  <= '0;
      io_wdata_q <= 8'h00;
      io_bit_q   <= 3'h0;
      io_val_q   <= 1'b0;
    end else begin
      io_rd_q <= accept && is_io;
      io_we_q <= (state_q == bfu_pkg::BFU_ST_IO);
      if (accept && is_io) begin
        io_addr_q <= op_io_addr;
        io_bit_q  <= op_bit;
        io_val_q  <= (op_code == bfu_pkg::OP_IO_BIT_RAISE);
      end
      if (state_q == bfu_pkg::BFU_ST_IO) begin
        io_wdata_q <= io_val_q
                    ? (io_rdata | (8'h01 << io_bit_q))
                    : (io_rdata & ~(8'h01 << io_bit_q));
      end
    end
  end

endmodule : bfu_core

/* File: verif/bfu_assertions.sv */
// port-level assertion checker for the bit and flag unit
`timescale 1ns/1ns
module bfu_chk (
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             sys_rst,
  // request side
  input wire logic             op_valid,
  input wire bfu_pkg::bfu_op_e op_code,
  input wire logic [7:0]       op_reg_val,
  input wire logic [6:0]       op_offset,
  input wire logic [15:0]      pc_now,
  input wire logic [7:0]       io_rdata,
  // results
  input wire logic             op_ready_q,
  input wire logic             done_q,
  input wire logic             reg_we_q,
  input wire logic [7:0]       reg_wdata_q,
  input wire logic             io_rd_q,
  input wire logic             io_we_q,
  input wire logic [4:0]       io_addr_q,
  input wire logic [7:0]       io_wdata_q,
  input wire logic             pc_load_q,
  input wire logic [15:0]      pc_next_q,
  input wire logic [7:0]       status_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire acc = op_valid && op_ready_q;
  io_write_a: assert property (
    io_rd_q |=> io_we_q && done_q && io_addr_q == $past(io_addr_q))
    else $error("io write step missing");
  io_onebit_a: assert property (
    io_we_q |-> $countones(io_wdata_q ^ $past(io_rdata)) <= 1)
    else $error("io write alters other bits");
  br_taken_a: assert property (
    acc && op_code == bfu_pkg::OP_BRANCH_IRQ_ON && status_q[7] |=>
    !done_q ##1 pc_load_q && pc_next_q == $past(pc_now, 2)
    + 16'($signed($past(op_offset, 2))) + 16'h0001)
    else $error("taken branch wrong");
  br_fall_a: assert property (
    acc && op_code == bfu_pkg::OP_BRANCH_IRQ_OFF && status_q[7] |=>
    done_q && !pc_load_q) else $error("untaken branch wrong");
  v_raise_a: assert property (
    acc && op_code == bfu_pkg::OP_OVERFLOW_RAISE |=>
    status_q == ($past(status_q) | 8'h08)) else $error("v raise wrong");
  v_drop_a: assert property (
    acc && op_code == bfu_pkg::OP_OVERFLOW_DROP |=>
    status_q == ($past(status_q) & 8'hf7)) else $error("v drop wrong");
  h_raise_a: assert property (
    acc && op_code == bfu_pkg::OP_HALF_CARRY_RAISE |=>
    status_q == ($past(status_q) | 8'h20)) else $error("h raise wrong");
  rol_a: assert property (
    acc && op_code == bfu_pkg::OP_ROTATE_LEFT_VIA_CARRY |=> reg_we_q &&
    {status_q[0], reg_wdata_q} == {$past(op_reg_val), $past(status_q[0])})
    else $error("left rotate wrong");
  ror_a: assert property (
    acc && op_code == bfu_pkg::OP_ROTATE_RIGHT_VIA_CARRY |=> reg_we_q &&
    {reg_wdata_q, status_q[0]} == {$past(status_q[0]), $past(op_reg_val)})
    else $error("right rotate wrong");
  op_done_a: assert property (
    acc |-> ##[1:2] done_q) else $error("no completion");
endmodule : bfu_chk

bind bfu_core bfu_chk bfu_chk_inst (.*);

/* File: verif/tb.sv */
// self-checking testbench for the bit and flag unit
`timescale 1ns/1ns
module tb;
  logic             sys_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             op_valid = 1'b0;
  bfu_pkg::bfu_op_e op_code = bfu_pkg::OP_BRANCH_IRQ_ON;
  logic [7:0]       op_reg_val = 8'h00;
  logic [2:0]       op_bit = 3'h0;
  logic [4:0]       op_io_addr = 5'h00;
  logic [6:0]       op_offset = 7'h00;
  logic [15:0]      pc_now = 16'h0000;
  logic [7:0]       io_rdata = 8'h00;
  logic op_ready_q, done_q, reg_we_q, io_rd_q, io_we_q, pc_load_q;
  logic [7:0]       reg_wdata_q, io_wdata_q, status_q;
  logic [4:0]       io_addr_q;
  logic [15:0]      pc_next_q;
  int               fail_count = 0;
  int               checks_done = 0;
  logic [7:0]       st = 8'h00;
  int               fi[8] = '{0, 2, 1, 7, 4, 3, 6, 5};

  always #5 sys_clk = ~sys_clk;

  bfu_core bfu_core_inst (.*);

  task automatic check(input logic [15:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // -------------------------------------------------------------
  // one instruction against the bench model
  // -------------------------------------------------------------
  task automatic run(input logic [4:0] o);
    logic [7:0] v, r, rd;
    logic [2:0] b;
    logic [4:0] a;
    logic [6:0] off;
    logic [15:0] pc;
    logic c, tk, we, io;
    int n;
    v = 8'($urandom);
    b = 3'($urandom);
    rd = 8'($urandom);
    a = 5'($urandom);
    off = 7'($urandom);
    pc = 16'($urandom);
    r = v;
    c = st[0];
    tk = 1'b0;
    we = 1'b1;
    io = 1'b0;
    op_code <= bfu_pkg::bfu_op_e'(o);
    op_reg_val <= v;
    op_bit <= b;
    op_io_addr <= a;
    op_offset <= off;
    pc_now <= pc;
    io_rdata <= rd;
    op_valid <= 1'b1;
    case (o)
      5'h00, 5'h01: begin we = 0; tk = st[7] ^ o[0]; end
      5'h02, 5'h03: begin we = 0; io = 1; end
      5'h04: begin r = v << 1; c = v[7]; end
      5'h05: begin r = v >> 1; c = v[0]; end
      5'h06: begin r = {v[6:0], st[0]}; c = v[7]; end
      5'h07: begin r = {st[0], v[7:1]}; c = v[0]; end
      5'h08: begin r = {v[7], v[7:1]}; c = v[0]; end
      5'h09: r = {v[3:0], v[7:4]};
      5'h0A, 5'h0B: begin we = 0; st[b] = !o[0]; end
      5'h0C: begin we = 0; st[6] = v[b]; end
      5'h0D: r[b] = st[6];
      default: begin we = 0; st[fi[(o - 14) / 2]] = !o[0]; end
    endcase
    if (o inside {[5'h04:5'h08]})
      st[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(io_rd_q, io, "io read");
    check(op_ready_q, !(io || tk), "ready");
    n = 1;
    // ready stays low meanwhile, so the held request must be ignored
    while (done_q !== 1'b1 && n < 3) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(n), (io || tk) ? 16'h2 : 16'h1, "cycles");
    check(status_q, st, "flags");
    check(reg_we_q, we, "write back");
    if (we) check(reg_wdata_q, r, "result");
    check(pc_load_q, tk, "branch");
    if (tk)
      check(pc_next_q, pc + 16'($signed(off)) + 16'h1, "pc");
    check(io_we_q, io, "io write");
    if (io) check({io_addr_q, io_wdata_q}, {a, o[0] ? rd & ~(8'h1 << b)
      : rd | (8'h1 << b)}, "io data");
  endtask : run

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    void'($urandom(32'h58a6));
    repeat (2) @(negedge sys_clk);
    sys_rst <= 1'b0;
    check({op_ready_q, done_q, reg_we_q, io_rd_q, io_we_q, pc_load_q,
           status_q}, 16'h2000, "reset state");
    for (int i = 0; i < 30; i++) run(5'(i));
    op_valid <= 1'b0;
    $display("test sweep done");
    @(negedge sys_clk);
    repeat (400) run(5'($urandom_range(29)));
    op_valid <= 1'b0;
    $display("test random done");
    conclude();
  end

  initial begin
    #50000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : tb
